// file: pkg/drs_pkg.sv
// Shared constants and types for the mode-register set-point block.
// Assumes both ends run on one clock and one synchronous reset.
package drs_pkg;
   // Mode register addresses on the command bus.
   localparam logic [7:0] DRS_MA_OPTION = 8'h0d;
   localparam logic [7:0] DRS_MA_DQREF = 8'h0e;
   // Option control register field positions.
   localparam int DRS_OPT_TRAIN = 0;
   localparam int DRS_OPT_PREAMBLE = 1;
   localparam int DRS_OPT_REFOUT = 2;
   localparam int DRS_OPT_FASTSETTLE = 3;
   localparam int DRS_OPT_RATEOPT = 4;
   localparam int DRS_OPT_MASKDIS = 5;
   localparam int DRS_OPT_FSPWR = 6;
   localparam int DRS_OPT_FSPOP = 7;
   localparam logic [7:0] DRS_OPT_RESET = 8'h00;
   // Data-reference register layout.
   localparam int DRS_REF_RANGE = 6;
   localparam logic [5:0] DRS_LEVEL_MAX = 6'h32;
   localparam logic [5:0] DRS_LEVEL_RESET = 6'h0d;
   localparam logic DRS_RANGE_RESET = 1'b1;
   // Refresh-rate report codes that the option bit hides.
   localparam logic [2:0] DRS_RATE_HIDDEN_A = 3'h1;
   localparam logic [2:0] DRS_RATE_HIDDEN_B = 3'h2;
   localparam logic [2:0] DRS_RATE_SUBST = 3'h3;
   localparam logic [5:0] DRS_CA_ZERO = 6'h00;
   localparam logic [7:0] DRS_BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {
      DRS_CMD_NOP,
      DRS_CMD_MRW,
      DRS_CMD_MRR,
      DRS_CMD_MASKWR
   } drs_cmd_t;

   typedef enum logic [1:0] {
      DRS_REQ_OPT_WR,
      DRS_REQ_REF_WR,
      DRS_REQ_REF_RD,
      DRS_REQ_MASKWR
   } drs_req_t;
endpackage

// file: pkg/drs_if.sv
// Command/address and data link between memory controller and device.
// Assumes both ends share clock; testbench connects the two modports.
`timescale 1ns/1ps
`default_nettype none
interface drs_if;
   import drs_pkg::*;
   logic cke;
   logic cmdValid;
   drs_cmd_t cmdKind;
   logic [7:0] addr;
   logic [7:0] op;
   logic [5:0] ca;
   logic [7:0] dqOut;
   logic dqOe;
   logic dqValid;
   logic [2:0] refreshCode;

   modport device (
      input cke, cmdValid, cmdKind, addr, op, ca,
      output dqOut, dqOe, dqValid, refreshCode
   );
   modport controller (
      output cke, cmdValid, cmdKind, addr, op, ca,
      input dqOut, dqOe, dqValid, refreshCode
   );
endinterface
`default_nettype wire

// file: verilog/drs_device.sv
// Device end: option control register and the two set-point copies of the
// data-reference register, with read-back and training reflection.
// Assumes the controller drives the link on the same clock edge domain.
//
// Notes on behaviour
// R1 - Writing training bit one enters bus training.
// R2 - Training with clock enable low reflects address.
// R3 - Controller raises clock enable before clearing training.
// R4 - Reference output uses only operating set point.
// R5 - Fast-settle bit selects high-current reference mode.
// R6 - Rate option matters only when feature capable.
// R7 - Option clear reports 011 instead of 001/010.
// R8 - Controller applies reported refresh code regardless.
// R9 - Mask disable makes masked writes illegal.
// R10 - Write set point picks accessed reference copy.
// R11 - Operating set point picks controlling reference copy.
// R12 - Reference register: level 5:0, range bit 6.
// R13 - Reference read drives lower byte, reserved zero.
// R14 - Two copies; access only write-selected copy.
// R15 - Inactive copy never affects operation.
// R16 - Written range held until overwrite or reset.
// R17 - Controller always writes range with level code.
// R18 - Level codes above 110010 are reserved.
// R19 - Option register is write-only, eight defined bits.
// R20 - Reset loads defaults; option bits cleared.
`timescale 1ns/1ps
`default_nettype none
module drs_device
   import drs_pkg::*;
(
   input wire logic clock, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   drs_if.device bus, // Command link from the controller.
   input wire logic featureCapable, // Device supports the refresh-rate option.
   input wire logic [2:0] thermalCode, // Raw refresh-rate code from the sensor.
   output logic trainingActive, // Command bus training mode.
   output logic preambleTraining, // Read preamble training enabled.
   output logic refOutEnable, // Reference voltage is driven to the pins.
   output logic [5:0] refOutLevel, // Level shown while reference output is on.
   output logic refOutRange, // Range shown while reference output is on.
   output logic fastSettle, // Reference circuit in high-current mode.
   output logic maskDisable, // Data masking disabled.
   output logic maskedWriteIllegal, // Pulse: masked write while masking is off.
   output logic [5:0] activeLevel, // Operating reference level code.
   output logic activeRange // Operating reference range.
);
   logic [7:0] optionReg;
   logic [6:0] dqRefReg [2];
   logic ignoreAll;
   logic cmdTake;
   logic wrSel;
   logic opSel;
   logic [2:0] rateCode;
   logic [7:0] dqOutReg;
   logic dqOeReg;
   logic dqValidReg;
   logic [2:0] refreshCodeReg;
   logic trainingReg;
   logic preambleReg;
   logic refOutEnReg;
   logic [5:0] refOutLevelReg;
   logic refOutRangeReg;
   logic fastSettleReg;
   logic maskDisableReg;
   logic illegalReg;
   logic [5:0] activeLevelReg;
   logic activeRangeReg;

   // While training with clock enable low the command decoder is blind.
   assign ignoreAll = optionReg[DRS_OPT_TRAIN] && !bus.cke; // R2
   assign cmdTake = bus.cmdValid && !ignoreAll;
   assign wrSel = optionReg[DRS_OPT_FSPWR]; // R10
   assign opSel = optionReg[DRS_OPT_FSPOP]; // R11

   // The option register cannot be read back; only its effects are visible.
   always_ff @(posedge clock) begin
      if (srst) begin
         optionReg <= DRS_OPT_RESET; // R20
      end else if (cmdTake && bus.cmdKind == DRS_CMD_MRW && bus.addr == DRS_MA_OPTION) begin
         optionReg <= bus.op; // R1 R19
      end
   end

   // Only the copy named by the write selector is reached. A reserved level
   // code is dropped whole so the held setting never becomes undefined.
   always_ff @(posedge clock) begin
      if (srst) begin
         dqRefReg[0] <= {DRS_RANGE_RESET, DRS_LEVEL_RESET}; // R20
         dqRefReg[1] <= {DRS_RANGE_RESET, DRS_LEVEL_RESET}; // R20
      end else if (cmdTake && bus.cmdKind == DRS_CMD_MRW && bus.addr == DRS_MA_DQREF
                   && bus.op[5:0] <= DRS_LEVEL_MAX) begin // R18
         dqRefReg[wrSel] <= bus.op[6:0]; // R12 R14 R16
      end
   end

   // Read data and training reflection share the lower data byte.
   always_ff @(posedge clock) begin
      if (srst) begin
         dqOutReg <= DRS_BYTE_ZERO;
         dqOeReg <= 1'b0;
         dqValidReg <= 1'b0;
      end else if (ignoreAll) begin
         dqOutReg <= {2'b00, bus.ca}; // R2
         dqOeReg <= 1'b1;
         dqValidReg <= 1'b1;
      end else if (cmdTake && bus.cmdKind == DRS_CMD_MRR) begin
         if (bus.addr == DRS_MA_DQREF) begin
            dqOutReg <= {1'b0, dqRefReg[wrSel]}; // R13 R14
         end else begin
            dqOutReg <= DRS_BYTE_ZERO;
         end
         dqOeReg <= 1'b1;
         dqValidReg <= 1'b1;
      end else begin
         dqOutReg <= DRS_BYTE_ZERO;
         dqOeReg <= 1'b0;
         dqValidReg <= 1'b0;
      end
   end

   // Hiding the two fast-refresh codes only applies to capable parts.
   always_comb begin
      rateCode = thermalCode;
      if (featureCapable && !optionReg[DRS_OPT_RATEOPT]) begin // R6
         if (thermalCode == DRS_RATE_HIDDEN_A || thermalCode == DRS_RATE_HIDDEN_B) begin
            rateCode = DRS_RATE_SUBST; // R7
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         refreshCodeReg <= DRS_RATE_SUBST;
      end else begin
         refreshCodeReg <= rateCode;
      end
   end

   // Control outputs follow the option register one cycle later.
   always_ff @(posedge clock) begin
      if (srst) begin
         trainingReg <= 1'b0;
         preambleReg <= 1'b0;
         fastSettleReg <= 1'b0;
         maskDisableReg <= 1'b0;
      end else begin
         trainingReg <= optionReg[DRS_OPT_TRAIN]; // R1
         preambleReg <= optionReg[DRS_OPT_PREAMBLE];
         fastSettleReg <= optionReg[DRS_OPT_FASTSETTLE]; // R5
         maskDisableReg <= optionReg[DRS_OPT_MASKDIS]; // R9
      end
   end

   // The operating copy alone steers the reference; edits to the other copy
   // are invisible here until the operating selector flips.
   always_ff @(posedge clock) begin
      if (srst) begin
         activeLevelReg <= DRS_LEVEL_RESET;
         activeRangeReg <= DRS_RANGE_RESET;
      end else begin
         activeLevelReg <= dqRefReg[opSel][5:0]; // R11 R15
         activeRangeReg <= dqRefReg[opSel][DRS_REF_RANGE]; // R11 R15
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         refOutEnReg <= 1'b0;
         refOutLevelReg <= DRS_LEVEL_RESET;
         refOutRangeReg <= DRS_RANGE_RESET;
      end else begin
         refOutEnReg <= optionReg[DRS_OPT_REFOUT]; // R4
         refOutLevelReg <= dqRefReg[opSel][5:0]; // R4
         refOutRangeReg <= dqRefReg[opSel][DRS_REF_RANGE]; // R4
      end
   end

   // A masked write with masking off is dropped and flagged for one cycle.
   always_ff @(posedge clock) begin
      if (srst) begin
         illegalReg <= 1'b0;
      end else begin
         illegalReg <= cmdTake && bus.cmdKind == DRS_CMD_MASKWR && optionReg[DRS_OPT_MASKDIS]; // R9
      end
   end

   assign bus.dqOut = dqOutReg;
   assign bus.dqOe = dqOeReg;
   assign bus.dqValid = dqValidReg;
   assign bus.refreshCode = refreshCodeReg;
   assign trainingActive = trainingReg;
   assign preambleTraining = preambleReg;
   assign refOutEnable = refOutEnReg;
   assign refOutLevel = refOutLevelReg;
   assign refOutRange = refOutRangeReg;
   assign fastSettle = fastSettleReg;
   assign maskDisable = maskDisableReg;
   assign maskedWriteIllegal = illegalReg;
   assign activeLevel = activeLevelReg;
   assign activeRange = activeRangeReg;
endmodule
`default_nettype wire

// file: verilog/drs_controller.sv
// Controller end: turns user requests into mode register commands.
// Assumes the device end sits on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module drs_controller
   import drs_pkg::*;
(
   input wire logic clock, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   drs_if.controller bus, // Command link to the device.
   input wire logic reqValid, // Request present.
   input wire drs_req_t reqKind, // Request kind.
   input wire logic [7:0] reqData, // Option byte, or range and level.
   input wire logic ckeLowReq, // Drop clock enable while training.
   input wire logic [5:0] caPattern, // Address pattern sent during training.
   output logic reqReady, // Request accepted this cycle.
   output logic reqReject, // Pulse: request refused.
   output logic rdValid, // Pulse: read data present.
   output logic [7:0] rdData, // Read data.
   output logic [2:0] refreshMode // Refresh mode being applied.
);
   typedef enum {DRS_IDLE, DRS_RAISE} drs_state_t;
   drs_state_t stateReg;
   logic [7:0] optShadowReg;
   logic ckeReg;
   logic cmdValidReg;
   drs_cmd_t cmdKindReg;
   logic [7:0] addrReg;
   logic [7:0] opReg;
   logic readyReg;
   logic rejectReg;
   logic rdValidReg;
   logic [7:0] rdDataReg;
   logic [2:0] refreshReg;
   logic readPendReg;
   logic clearTrain;
   logic badReq;
   logic issue;

   assign clearTrain = reqKind == DRS_REQ_OPT_WR && optShadowReg[DRS_OPT_TRAIN] && !reqData[DRS_OPT_TRAIN];
   assign badReq = (reqKind == DRS_REQ_MASKWR && optShadowReg[DRS_OPT_MASKDIS]) // R9
                   || (reqKind == DRS_REQ_REF_WR && reqData[5:0] > DRS_LEVEL_MAX); // R18
   // Leaving training waits one cycle with clock enable high first.
   assign issue = reqValid && stateReg == DRS_IDLE && !badReq && !(clearTrain && !ckeReg); // R3

   always_ff @(posedge clock) begin
      if (srst) begin
         stateReg <= DRS_IDLE;
      end else begin
         case (stateReg)
            DRS_IDLE: begin
               if (reqValid && !badReq && clearTrain && !ckeReg) begin
                  stateReg <= DRS_RAISE; // R3
               end
            end
            DRS_RAISE: stateReg <= DRS_IDLE;
            default: stateReg <= DRS_IDLE;
         endcase
      end
   end

   // Clock enable may only drop while training is on.
   always_ff @(posedge clock) begin
      if (srst) begin
         ckeReg <= 1'b1;
      end else if (stateReg != DRS_IDLE || (reqValid && clearTrain)) begin
         ckeReg <= 1'b1; // R3
      end else begin
         ckeReg <= !(ckeLowReq && optShadowReg[DRS_OPT_TRAIN]);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         optShadowReg <= DRS_OPT_RESET;
      end else if (issue && reqKind == DRS_REQ_OPT_WR) begin
         optShadowReg <= reqData;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cmdValidReg <= 1'b0;
         cmdKindReg <= DRS_CMD_NOP;
         addrReg <= DRS_BYTE_ZERO;
         opReg <= DRS_BYTE_ZERO;
      end else begin
         cmdValidReg <= issue;
         cmdKindReg <= DRS_CMD_NOP;
         addrReg <= DRS_BYTE_ZERO;
         opReg <= reqData;
         if (issue) begin
            case (reqKind)
               DRS_REQ_OPT_WR: begin
                  cmdKindReg <= DRS_CMD_MRW;
                  addrReg <= DRS_MA_OPTION;
               end
               DRS_REQ_REF_WR: begin
                  cmdKindReg <= DRS_CMD_MRW;
                  addrReg <= DRS_MA_DQREF;
                  opReg <= {1'b0, reqData[6:0]}; // R17
               end
               DRS_REQ_REF_RD: begin
                  cmdKindReg <= DRS_CMD_MRR;
                  addrReg <= DRS_MA_DQREF;
               end
               default: cmdKindReg <= DRS_CMD_MASKWR;
            endcase
         end
      end
   end

   // Only the answer to our own read counts. The reflection byte still in
   // flight when clock enable rises must not look like read data.
   always_ff @(posedge clock) begin
      if (srst) begin
         readPendReg <= 1'b0;
      end else begin
         readPendReg <= cmdValidReg && cmdKindReg == DRS_CMD_MRR && ckeReg;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         readyReg <= 1'b0;
         rejectReg <= 1'b0;
         rdValidReg <= 1'b0;
         rdDataReg <= DRS_BYTE_ZERO;
         refreshReg <= DRS_RATE_SUBST;
      end else begin
         readyReg <= issue;
         rejectReg <= reqValid && stateReg == DRS_IDLE && badReq;
         rdValidReg <= bus.dqValid && readPendReg;
         rdDataReg <= bus.dqOut;
         refreshReg <= bus.refreshCode; // R8
      end
   end

   assign bus.cke = ckeReg;
   assign bus.cmdValid = cmdValidReg;
   assign bus.cmdKind = cmdKindReg;
   assign bus.addr = addrReg;
   assign bus.op = opReg;
   assign bus.ca = caPattern;
   assign reqReady = readyReg;
   assign reqReject = rejectReg;
   assign rdValid = rdValidReg;
   assign rdData = rdDataReg;
   assign refreshMode = refreshReg;
endmodule
`default_nettype wire

// file: verif/drs_chk.sv
// Checker for the link between the two ends.
// Assumes it watches the interface signals on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module drs_chk
   import drs_pkg::*;
(
   input wire logic clock, // Clock.
   input wire logic srst, // Reset.
   input wire logic cke, // Clock enable.
   input wire logic cmdValid, // Command present.
   input wire drs_cmd_t cmdKind, // Command kind.
   input wire logic [7:0] addr, // Address.
   input wire logic [7:0] op, // Operand.
   input wire logic [5:0] ca, // Pattern.
   input wire logic [7:0] dqOut, // Data byte.
   input wire logic dqOe, // Data drive.
   input wire logic dqValid, // Data valid.
   input wire logic [2:0] refreshCode // Refresh code.
);
   logic [7:0] opt_reg;
   logic [6:0] copies_reg [2];
   logic [7:0] expRd_reg;
   logic frozen;
   logic isMrw;
   logic isMrr;
   // Commands seen while training with clock enable low are dropped by the device.
   assign frozen = opt_reg[DRS_OPT_TRAIN] && !cke;
   assign isMrw = cmdValid && cmdKind == DRS_CMD_MRW && !frozen;
   assign isMrr = cmdValid && cmdKind == DRS_CMD_MRR && !frozen;
   always_ff @(posedge clock) begin
      if (srst) begin
         opt_reg <= DRS_OPT_RESET;
      end else if (isMrw && addr == DRS_MA_OPTION) begin
         opt_reg <= op;
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         copies_reg[0] <= {DRS_RANGE_RESET, DRS_LEVEL_RESET};
         copies_reg[1] <= {DRS_RANGE_RESET, DRS_LEVEL_RESET};
      end else if (isMrw && addr == DRS_MA_DQREF && op[5:0] <= DRS_LEVEL_MAX) begin
         copies_reg[opt_reg[DRS_OPT_FSPWR]] <= op[6:0];
      end
   end
   always_ff @(posedge clock) begin
      expRd_reg <= (addr == DRS_MA_DQREF) ? {1'b0, copies_reg[opt_reg[DRS_OPT_FSPWR]]} : DRS_BYTE_ZERO;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   read_copy_a: assert property (isMrr |=> dqValid && dqOe && dqOut == expRd_reg)
      else $error("read data differs from selected copy");
   read_pad_a: assert property (isMrr |=> dqOut[7] == 1'b0)
      else $error("reserved read bit not zero");
   ca_reflect_a: assert property (frozen && $past(frozen) |=> dqOe && dqOut == {2'b00, $past(ca)})
      else $error("training pattern not reflected");
   dq_cause_a: assert property (dqValid |-> $past(isMrr) || $past(frozen))
      else $error("data driven without cause");
   cke_train_a: assert property (!cke |-> opt_reg[DRS_OPT_TRAIN])
      else $error("clock enable low outside training");
   clear_high_a: assert property (cmdValid && cmdKind == DRS_CMD_MRW && addr == DRS_MA_OPTION && !op[DRS_OPT_TRAIN] |-> cke)
      else $error("training cleared with clock enable low");
   level_ok_a: assert property (cmdValid && cmdKind == DRS_CMD_MRW && addr == DRS_MA_DQREF |-> op[5:0] <= DRS_LEVEL_MAX && !op[7])
      else $error("reserved level written");
   reset_state_a: assert property ($past(srst) |-> refreshCode == DRS_RATE_SUBST && !dqValid)
      else $error("wrong state after reset");
   cover property (isMrr);
   cover property (frozen && $past(frozen));
   cover property (isMrw && addr == DRS_MA_DQREF && opt_reg[DRS_OPT_FSPWR]);
endmodule
`default_nettype wire

// file: verif/dram_mode_reg_setpoints_tb.sv
// Testbench joining controller and device ends through the link.
// Assumes one 100 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dram_mode_reg_setpoints_tb;
   import drs_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic reqValid = 1'b0;
   drs_req_t reqKind = DRS_REQ_REF_RD;
   logic [7:0] reqData = 8'h00;
   logic ckeLowReq = 1'b0;
   logic [5:0] caPattern = 6'h00;
   logic featureCapable = 1'b1;
   logic [2:0] thermalCode = 3'h1;
   logic reqReady, reqReject, rdValid, trainingActive, preambleTraining, refOutEnable;
   logic refOutRange, fastSettle, maskDisable, activeRange, maskedWriteIllegal;
   logic [7:0] rdData;
   logic [2:0] refreshMode;
   logic [5:0] refOutLevel, activeLevel;
   int mismatches = 0;
   int compares = 0;
   drs_if link();
   drs_controller u_drs_controller(.clock(clock), .srst(srst), .bus(link), .reqValid(reqValid),
      .reqKind(reqKind), .reqData(reqData), .ckeLowReq(ckeLowReq), .caPattern(caPattern),
      .reqReady(reqReady), .reqReject(reqReject), .rdValid(rdValid), .rdData(rdData), .refreshMode(refreshMode));
   drs_device u_drs_device(.clock(clock), .srst(srst), .bus(link), .featureCapable(featureCapable),
      .thermalCode(thermalCode), .trainingActive(trainingActive), .preambleTraining(preambleTraining),
      .refOutEnable(refOutEnable), .refOutLevel(refOutLevel), .refOutRange(refOutRange), .fastSettle(fastSettle),
      .maskDisable(maskDisable), .maskedWriteIllegal(maskedWriteIllegal), .activeLevel(activeLevel),
      .activeRange(activeRange));
   drs_chk u_drs_chk(.clock(clock), .srst(srst), .cke(link.cke), .cmdValid(link.cmdValid), .cmdKind(link.cmdKind),
      .addr(link.addr), .op(link.op), .ca(link.ca), .dqOut(link.dqOut), .dqOe(link.dqOe), .dqValid(link.dqValid),
      .refreshCode(link.refreshCode));
   always #5 clock = ~clock;
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Holds the request until accepted or refused, then leaves one idle edge.
   task automatic request(input drs_req_t kind, input logic [7:0] data, input logic rej);
      int i;
      i = 0;
      reqKind = kind;
      reqData = data;
      reqValid = 1'b1;
      do begin
         tick(1);
         i++;
      end while (i < 8 && reqReady !== 1'b1 && reqReject !== 1'b1);
      reqValid = 1'b0;
      check(8'({reqReady, reqReject}), rej ? 8'h01 : 8'h02);
      tick(1);
   endtask
   task automatic read_ref(input logic [7:0] exp);
      int i;
      i = 0;
      request(DRS_REQ_REF_RD, 8'h00, 1'b0);
      while (i < 6 && rdValid !== 1'b1) begin
         tick(1);
         i++;
      end
      check(rdData, exp);
   endtask
   task automatic do_reset();
      srst = 1'b1;
      tick(4);
      srst = 1'b0;
   endtask
   task automatic t_defaults();
      tick(3);
      check(8'({activeRange, activeLevel}), 8'h4d);
      check(8'({trainingActive, preambleTraining, refOutEnable, fastSettle, maskDisable}), 8'h00);
      check(8'(refreshMode), 8'h03);
      read_ref(8'h4d);
   endtask
   task automatic t_setpoints();
      request(DRS_REQ_OPT_WR, 8'h00, 1'b0);
      request(DRS_REQ_REF_WR, 8'h2a, 1'b0);
      request(DRS_REQ_OPT_WR, 8'h40, 1'b0);
      request(DRS_REQ_REF_WR, 8'h72, 1'b0);
      read_ref(8'h72);
      check(8'({activeRange, activeLevel}), 8'h2a);
      request(DRS_REQ_OPT_WR, 8'h00, 1'b0);
      read_ref(8'h2a);
      request(DRS_REQ_OPT_WR, 8'hc4, 1'b0);
      tick(2);
      check(8'({activeRange, activeLevel}), 8'h72);
      check({refOutEnable, refOutRange, refOutLevel}, 8'hf2);
      read_ref(8'h72);
   endtask
   task automatic t_reserved();
      request(DRS_REQ_REF_WR, 8'h33, 1'b1);
      read_ref(8'h72);
   endtask
   task automatic t_options();
      request(DRS_REQ_OPT_WR, 8'h2a, 1'b0);
      tick(2);
      check(8'({preambleTraining, refOutEnable, fastSettle, maskDisable}), 8'h0b);
      request(DRS_REQ_OPT_WR, 8'h14, 1'b0);
      tick(3);
      check(8'({preambleTraining, refOutEnable, fastSettle, maskDisable}), 8'h04);
      check(8'(link.refreshCode), 8'h01);
      check(8'(refreshMode), 8'h01);
      request(DRS_REQ_OPT_WR, 8'h00, 1'b0);
      featureCapable = 1'b0;
      thermalCode = 3'h2;
      tick(3);
      check(8'(refreshMode), 8'h02);
      featureCapable = 1'b1;
      tick(3);
      check(8'(refreshMode), 8'h03);
   endtask
   task automatic t_mask();
      request(DRS_REQ_OPT_WR, 8'h20, 1'b0);
      request(DRS_REQ_MASKWR, 8'h00, 1'b1);
      request(DRS_REQ_OPT_WR, 8'h00, 1'b0);
      request(DRS_REQ_MASKWR, 8'h00, 1'b0);
      check(8'(maskedWriteIllegal), 8'h00);
   endtask
   task automatic t_training();
      request(DRS_REQ_OPT_WR, 8'h01, 1'b0);
      tick(2);
      check(8'(trainingActive), 8'h01);
      caPattern = 6'h2b;
      ckeLowReq = 1'b1;
      tick(3);
      check(link.dqOut, 8'h2b);
      request(DRS_REQ_REF_WR, 8'h11, 1'b0);
      caPattern = 6'h15;
      tick(1);
      check(link.dqOut, 8'h15);
      request(DRS_REQ_OPT_WR, 8'h00, 1'b0);
      tick(2);
      check(8'({link.cke, trainingActive}), 8'h02);
      ckeLowReq = 1'b0;
      read_ref(8'h2a);
   endtask
   initial begin
      repeat (3000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
   initial begin
      do_reset();
      t_defaults();
      t_setpoints();
      t_reserved();
      t_options();
      t_mask();
      t_training();
      do_reset();
      t_defaults();
      give_verdict();
   end
endmodule
`default_nettype wire
